// ---- design/indirect_window.sv ----
`timescale 1ns/1ps
`default_nettype none
module indirect_window
  import port_link_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  reg_access_if.target bus,
  input wire logic [15:0] serdes_rdata,
  output logic serdes_wr,
  output logic serdes_rd,
  output logic [15:0] serdes_wdata,
  output logic [4:0] serdes_dev,
  output logic serdes_vendor_space,
  output logic [7:0] serdes_reg_offs
);

  logic [SD_ADDR_W-1:0] addr_q;
  logic step_q;
  logic [15:0] data_q;
  logic [SD_ADDR_W-1:0] acc_q;
  logic wr_q;
  logic rd_q;
  wire addr_wr = bus.wr & ~bus.sel;
  wire data_acc = (bus.wr | bus.rd) & bus.sel;
  wire [SD_ADDR_W-1:0] addr_next = SD_ADDR_W'(addr_q + 1'b1);

  // Read of the data register returns the target's current word
  assign bus.rdata = bus.sel ? {16'h0000, serdes_rdata}
                             : {8'h00, step_q, 2'h0, addr_q};

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= SD_ADDR_RST;
      step_q <= STEP_EN_RST;
    end else if (addr_wr) begin
      addr_q <= bus.wdata[SD_ADDR_W-1:0];
      step_q <= bus.wdata[STEP_EN_BIT];
    end else if (data_acc && step_q) begin
      addr_q <= addr_next;
    end
  end

  // Access carries the address in force before any step
  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= SD_DATA_RST;
      acc_q <= SD_ADDR_RST;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= bus.wr & bus.sel;
      rd_q <= bus.rd & bus.sel;
      if (data_acc) acc_q <= addr_q;
      if (bus.wr && bus.sel) data_q <= bus.wdata[15:0];
      else if (bus.rd && bus.sel) data_q <= serdes_rdata;
    end
  end

  assign serdes_wr = wr_q;
  assign serdes_rd = rd_q;
  assign serdes_wdata = data_q;
  assign serdes_dev = acc_q[SD_ADDR_W-1:DEVAD_LSB];
  assign serdes_vendor_space = acc_q[SPACE_BIT];
  assign serdes_reg_offs = acc_q[REGOFF_W-1:0];

  property p_step;
    @(posedge clk) disable iff (rst)
      data_acc && step_q |=> addr_q == $past(addr_next);
  endproperty
  a_step: assert property (p_step) else $error("indirect address did not step");

  property p_fixed;
    @(posedge clk) disable iff (rst)
      data_acc && !step_q |=> $stable(addr_q) ##1 serdes_dev == $past(addr_q[20:16], 2);
  endproperty
  a_fixed: assert property (p_fixed) else $error("indirect address moved");

  property p_wr_pulse;
    @(posedge clk) disable iff (rst)
      bus.wr && bus.sel |=> serdes_wr && serdes_wdata == $past(bus.wdata[15:0])
        && serdes_reg_offs == $past(addr_q[7:0]) ##1 serdes_wr == $past(bus.wr && bus.sel);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("indirect write pulse wrong");

endmodule : indirect_window
`default_nettype wire

// ---- design/mac_port_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module mac_port_ctrl
  import port_link_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  reg_access_if.target bus,
  input wire logic fc_strap,
  output logic mac_full_duplex,
  output logic mac_tx_fc_en,
  output logic mac_rx_fc_en,
  output mac_speed_t mac_speed
);

  logic duplex_q;
  logic txfc_q;
  logic rxfc_q;
  logic spd_q;
  logic sel_q;
  logic strap_done_q;
  mac_speed_t speed_d;
  wire wr0 = bus.wr & ~bus.sel;
  wire wr1 = bus.wr & bus.sel;

  assign bus.rdata = bus.sel ? {24'h000000, 1'b0, sel_q, 6'h00}
    : {24'h000000, PP0_RSVD7_VAL, duplex_q, txfc_q, spd_q, rxfc_q, 3'h0};

  // Speed bit only counts outside gigabit
  // Companion bit picks gigabit or 10/100
  assign speed_d = !sel_q ? SPEED_1000 : (spd_q ? SPEED_100 : SPEED_10);

  // Flow control taken from strap after release
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_done_q <= 1'b0;
      txfc_q <= 1'b0;
      rxfc_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      txfc_q <= fc_strap;
      rxfc_q <= fc_strap;
    end else if (wr0) begin
      txfc_q <= bus.wdata[PP_TXFC_BIT];
      rxfc_q <= bus.wdata[PP_RXFC_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      duplex_q <= PP_DUPLEX_RST;
      spd_q <= PP_SPEED_RST;
      sel_q <= PP1_SEL_RST;
    end else begin
      if (wr0) duplex_q <= bus.wdata[PP_DUPLEX_BIT];
      if (wr0) spd_q <= bus.wdata[PP_SPEED_BIT];
      if (wr1) sel_q <= bus.wdata[PP1_SEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mac_full_duplex <= PP_DUPLEX_RST;
      mac_tx_fc_en <= 1'b0;
      mac_rx_fc_en <= 1'b0;
      mac_speed <= SPEED_1000;
    end else begin
      mac_full_duplex <= duplex_q;
      mac_tx_fc_en <= txfc_q;
      mac_rx_fc_en <= rxfc_q;
      mac_speed <= speed_d;
    end
  end

  property p_gig_ignores;
    @(posedge clk) disable iff (rst)
      !sel_q && $changed(spd_q) |=> mac_speed == SPEED_1000;
  endproperty
  a_gig_ignores: assert property (p_gig_ignores) else $error("speed bit acted in gigabit");

  property p_strap;
    @(posedge clk)
      $fell(rst) |-> ##2 mac_tx_fc_en == $past(fc_strap, 2) && mac_rx_fc_en == $past(fc_strap, 2);
  endproperty
  a_strap: assert property (p_strap) else $error("flow control not from strap");

  property p_fc_write;
    @(posedge clk) disable iff (rst)
      wr0 && strap_done_q |=> ##1 mac_tx_fc_en == $past(bus.wdata[5], 2)
        && mac_rx_fc_en == $past(bus.wdata[3], 2) && mac_full_duplex == $past(bus.wdata[6], 2);
  endproperty
  a_fc_write: assert property (p_fc_write) else $error("port control write lost");

endmodule : mac_port_ctrl
`default_nettype wire

// ---- design/port_link_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_link_config_regs
  import port_link_cfg_pkg::*;
#(
  parameter int REG_ADDR_W = ADDR_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic link_speed_1000,
  input wire logic link_speed_100,
  input wire logic link_speed_10,
  input wire logic link_full_duplex,
  input wire logic link_timing_master,
  input wire logic fc_strap,
  input wire logic [15:0] serdes_rdata,
  output logic xover_auto_en,
  output logic pairing_straight,
  output logic jabber_count_en,
  output logic serdes_wr,
  output logic serdes_rd,
  output logic [15:0] serdes_wdata,
  output logic [4:0] serdes_dev,
  output logic serdes_vendor_space,
  output logic [7:0] serdes_reg_offs,
  output logic mac_full_duplex,
  output logic mac_tx_fc_en,
  output logic mac_rx_fc_en,
  output mac_speed_t mac_speed
);

  // Offsets are 16 bits wide; any other port width, narrower or wider, is rejected
  if (REG_ADDR_W != ADDR_W) begin : g_bad_addr_w
    $error("REG_ADDR_W must equal the offset width");
  end

  logic manual_q;
  logic xover_off_q;
  logic jabber_q;
  logic [4:0] status_q;
  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] xover_rd;
  logic [DATA_W-1:0] xcvr_rd;

  reg_access_if sd_bus ();
  reg_access_if pp_bus ();

  // Address decode
  wire hit_xover = reg_addr == OFF_XOVER;
  wire hit_xcvr = reg_addr == OFF_XCVR;
  wire hit_sd_addr = reg_addr == OFF_SD_ADDR;
  wire hit_sd_data = reg_addr == OFF_SD_DATA;
  wire hit_pp0 = reg_addr == OFF_PP0;
  wire hit_pp1 = reg_addr == OFF_PP1;
  wire hit_sd = hit_sd_addr | hit_sd_data;
  wire hit_pp = hit_pp0 | hit_pp1;
  wire hit_any = hit_xover | hit_xcvr | hit_sd | hit_pp;
  wire wr_xover = reg_wr & hit_xover;
  wire wr_xcvr = reg_wr & hit_xcvr;

  assign sd_bus.wr = reg_wr & hit_sd;
  assign sd_bus.rd = reg_rd & hit_sd;
  assign sd_bus.sel = hit_sd_data;
  assign sd_bus.wdata = reg_wdata;

  assign pp_bus.wr = reg_wr & hit_pp;
  assign pp_bus.rd = reg_rd & hit_pp;
  assign pp_bus.sel = hit_pp1;
  assign pp_bus.wdata = reg_wdata;

  assign xover_rd = {24'h000000, manual_q, xover_off_q, 6'h00};
  assign xcvr_rd = {16'h0000, 6'h00, jabber_q, XCVR_RSVD_VAL, status_q, 2'h0};

  assign read_mux = hit_xover ? xover_rd
                  : hit_xcvr ? xcvr_rd
                  : hit_sd ? sd_bus.rdata
                  : hit_pp ? pp_bus.rdata
                  : 32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      manual_q <= XOVER_MANUAL_RST;
      xover_off_q <= XOVER_OFF_RST;
    end else if (wr_xover) begin
      manual_q <= reg_wdata[XOVER_MANUAL_BIT];
      xover_off_q <= reg_wdata[XOVER_OFF_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      jabber_q <= JABBER_RST;
    end else if (wr_xcvr) begin
      jabber_q <= reg_wdata[JABBER_BIT];
    end
  end

  // Resolved link status sampled each cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= 5'h00;
    end else begin
      status_q <= {link_speed_1000, link_speed_100, link_speed_10,
                   link_full_duplex, link_timing_master};
    end
  end

  // Manual pairing has no effect in automatic mode
  always_ff @(posedge clk) begin
    if (rst) begin
      xover_auto_en <= ~XOVER_OFF_RST;
      pairing_straight <= 1'b0;
      jabber_count_en <= JABBER_RST;
    end else begin
      xover_auto_en <= ~xover_off_q;
      pairing_straight <= xover_off_q & manual_q;
      jabber_count_en <= jabber_q;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 32'h00000000;
    end
  end

  indirect_window u_indirect (
    .clk(clk),
    .rst(rst),
    .bus(sd_bus.target),
    .serdes_rdata(serdes_rdata),
    .serdes_wr(serdes_wr),
    .serdes_rd(serdes_rd),
    .serdes_wdata(serdes_wdata),
    .serdes_dev(serdes_dev),
    .serdes_vendor_space(serdes_vendor_space),
    .serdes_reg_offs(serdes_reg_offs)
  );

  mac_port_ctrl u_mac_port (
    .clk(clk),
    .rst(rst),
    .bus(pp_bus.target),
    .fc_strap(fc_strap),
    .mac_full_duplex(mac_full_duplex),
    .mac_tx_fc_en(mac_tx_fc_en),
    .mac_rx_fc_en(mac_rx_fc_en),
    .mac_speed(mac_speed)
  );

  property p_manual_pairing;
    @(posedge clk) disable iff (rst)
      wr_xover && reg_wdata[6] |=> ##1 !xover_auto_en
        && pairing_straight == $past(reg_wdata[7], 2);
  endproperty
  a_manual_pairing: assert property (p_manual_pairing) else $error("manual pairing not applied");

  property p_auto_pairing;
    @(posedge clk) disable iff (rst)
      wr_xover && !reg_wdata[6] |=> ##1 xover_auto_en && !pairing_straight;
  endproperty
  a_auto_pairing: assert property (p_auto_pairing) else $error("pairing bit acted in auto mode");

  property p_jabber;
    @(posedge clk) disable iff (rst)
      wr_xcvr |=> ##1 jabber_count_en == $past(reg_wdata[9], 2);
  endproperty
  a_jabber: assert property (p_jabber) else $error("jabber enable not applied");

  property p_status_read;
    @(posedge clk) disable iff (rst)
      reg_rd && hit_xcvr |=> reg_rdata[6:3] == $past({link_speed_1000, link_speed_100,
        link_speed_10, link_full_duplex}, 2);
  endproperty
  a_status_read: assert property (p_status_read) else $error("speed or duplex status wrong");

  property p_master_read;
    @(posedge clk) disable iff (rst)
      reg_rd && hit_xcvr |=> reg_rdata[2] == $past(link_timing_master, 2);
  endproperty
  a_master_read: assert property (p_master_read) else $error("master status wrong");

  property p_reserved_read;
    @(posedge clk) disable iff (rst)
      reg_rd && (hit_xcvr || hit_xover) |=> reg_rdata[31:10] == 22'h000000 && reg_rdata[1:0] == 2'h0
        && ($past(hit_xcvr) ? reg_rdata[8:7] == 2'h2 : {reg_rdata[9:8], reg_rdata[5:2]} == 6'h00);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved field read wrong");

  property p_unmapped;
    @(posedge clk) disable iff (rst)
      !reg_rd || !hit_any |=> reg_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("read data outside read slot");

  property p_reset_state;
    @(posedge clk)
      rst |=> reg_rdata == 32'h00000000 && xover_auto_en && !pairing_straight && jabber_count_en;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("outputs not at reset values");

  property p_reset_window;
    @(posedge clk)
      rst |=> serdes_dev == 5'h1F && !serdes_vendor_space && serdes_reg_offs == 8'h00
        && !serdes_wr && !serdes_rd && serdes_wdata == 16'h0000;
  endproperty
  a_reset_window: assert property (p_reset_window) else $error("indirect outputs not at reset values");

  property p_reset_mac;
    @(posedge clk)
      rst |=> mac_full_duplex && !mac_tx_fc_en && !mac_rx_fc_en && mac_speed == SPEED_1000;
  endproperty
  a_reset_mac: assert property (p_reset_mac) else $error("port outputs not at reset values");

  property p_data_read;
    @(posedge clk) disable iff (rst)
      reg_rd && hit_sd_data |=> reg_rdata == {16'h0000, $past(serdes_rdata)};
  endproperty
  a_data_read: assert property (p_data_read) else $error("indirect data read wrong");

  property p_data_strobes;
    @(posedge clk) disable iff (rst)
      hit_sd_data && (reg_wr || reg_rd) |=> serdes_wr == $past(reg_wr) && serdes_rd == $past(reg_rd);
  endproperty
  a_data_strobes: assert property (p_data_strobes) else $error("indirect strobe missing");

  property p_data_quiet;
    @(posedge clk) disable iff (rst)
      !(hit_sd_data && (reg_wr || reg_rd)) |=> !serdes_wr && !serdes_rd;
  endproperty
  a_data_quiet: assert property (p_data_quiet) else $error("indirect strobe without data access");

  property p_addr_read;
    @(posedge clk) disable iff (rst)
      reg_rd && hit_sd_addr |=> reg_rdata[31:24] == 8'h00 && reg_rdata[22:21] == 2'h0;
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("address register reserved bits set");

  property p_pp0_read;
    @(posedge clk) disable iff (rst)
      reg_rd && hit_pp0 |=> reg_rdata[31:7] == 25'h0 && reg_rdata[2:0] == 3'h0;
  endproperty
  a_pp0_read: assert property (p_pp0_read) else $error("port control reserved bits set");

  property p_pp1_read;
    @(posedge clk) disable iff (rst)
      reg_rd && hit_pp1 |=> reg_rdata[31:7] == 25'h0 && reg_rdata[5:0] == 6'h00;
  endproperty
  a_pp1_read: assert property (p_pp1_read) else $error("companion register reserved bits set");

  property p_xover_hold;
    @(posedge clk) disable iff (rst)
      !wr_xover |=> ##1 $stable(xover_auto_en) && $stable(pairing_straight);
  endproperty
  a_xover_hold: assert property (p_xover_hold) else $error("crossover outputs moved without write");

  property p_jabber_hold;
    @(posedge clk) disable iff (rst)
      !wr_xcvr |=> ##1 $stable(jabber_count_en);
  endproperty
  a_jabber_hold: assert property (p_jabber_hold) else $error("jabber enable moved without write");

  property p_gig_select;
    @(posedge clk) disable iff (rst)
      reg_wr && hit_pp1 && !reg_wdata[PP1_SEL_BIT] |=> ##1 mac_speed == SPEED_1000;
  endproperty
  a_gig_select: assert property (p_gig_select) else $error("gigabit not selected");

  property p_slow_select;
    @(posedge clk) disable iff (rst)
      reg_wr && hit_pp1 && reg_wdata[PP1_SEL_BIT] |=> ##1 mac_speed != SPEED_1000;
  endproperty
  a_slow_select: assert property (p_slow_select) else $error("10/100 not selected");

endmodule : port_link_config_regs
`default_nettype wire

// ---- inc/port_link_cfg_pkg.sv ----
package port_link_cfg_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [15:0] OFF_XOVER = 16'h0138;
  localparam logic [15:0] OFF_XCVR = 16'h013E;
  localparam logic [15:0] OFF_SD_ADDR = 16'h0200;
  localparam logic [15:0] OFF_SD_DATA = 16'h0206;
  localparam logic [15:0] OFF_PP0 = 16'h0300;
  localparam logic [15:0] OFF_PP1 = 16'h0301;

  // Crossover control fields
  localparam int XOVER_MANUAL_BIT = 7;
  localparam int XOVER_OFF_BIT = 6;
  localparam logic XOVER_MANUAL_RST = 1'b0;
  localparam logic XOVER_OFF_RST = 1'b0;

  // Transceiver control and status fields
  localparam int JABBER_BIT = 9;
  localparam logic JABBER_RST = 1'b1;
  localparam int XCVR_RSVD_LSB = 7;
  localparam logic [1:0] XCVR_RSVD_VAL = 2'h2;
  localparam int SPD1000_BIT = 6;
  localparam int SPD100_BIT = 5;
  localparam int SPD10_BIT = 4;
  localparam int DUPLEX_BIT = 3;
  localparam int MASTER_BIT = 2;

  // Indirect window fields
  localparam int STEP_EN_BIT = 23;
  localparam int SD_ADDR_W = 21;
  localparam int DEVAD_LSB = 16;
  localparam int SPACE_BIT = 15;
  localparam int REGOFF_W = 8;
  localparam logic [20:0] SD_ADDR_RST = 21'h1F0000;
  localparam logic [15:0] SD_DATA_RST = 16'h0000;
  localparam logic STEP_EN_RST = 1'b0;

  // Parallel MAC port control fields
  localparam int PP_DUPLEX_BIT = 6;
  localparam int PP_TXFC_BIT = 5;
  localparam int PP_SPEED_BIT = 4;
  localparam int PP_RXFC_BIT = 3;
  localparam int PP1_SEL_BIT = 6;
  localparam logic PP_DUPLEX_RST = 1'b1;
  localparam logic PP_SPEED_RST = 1'b1;
  localparam logic PP1_SEL_RST = 1'b0;
  localparam logic PP0_RSVD7_VAL = 1'b0;

  typedef enum logic [1:0] {
    SPEED_10 = 2'h0,
    SPEED_100 = 2'h1,
    SPEED_1000 = 2'h2
  } mac_speed_t;

endpackage : port_link_cfg_pkg

// ---- inc/reg_access_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  import port_link_cfg_pkg::*;
  logic wr;
  logic rd;
  logic sel;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport decoder (output wr, output rd, output sel, output wdata, input rdata);
  modport target (input wr, input rd, input sel, input wdata, output rdata);
endinterface : reg_access_if
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp); end end
module tb;
  import port_link_cfg_pkg::*;
  logic clk;
  logic rst;
  logic reg_wr;
  logic reg_rd;
  logic fc_strap;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] rv;
  logic [15:0] serdes_rdata;
  logic [15:0] serdes_wdata;
  logic sp1000, sp100, sp10, full_dup, master;
  logic xover_auto_en, pairing_straight, jabber_count_en;
  logic serdes_wr, serdes_rd, serdes_vendor_space;
  logic [4:0] serdes_dev;
  logic [7:0] serdes_reg_offs;
  logic mac_full_duplex, mac_tx_fc_en, mac_rx_fc_en;
  mac_speed_t mac_speed;
  int failures = 0;
  int total_checks = 0;

  port_link_config_regs DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_speed_1000(sp1000), .link_speed_100(sp100),
    .link_speed_10(sp10), .link_full_duplex(full_dup), .link_timing_master(master),
    .fc_strap(fc_strap), .serdes_rdata(serdes_rdata), .xover_auto_en(xover_auto_en),
    .pairing_straight(pairing_straight), .jabber_count_en(jabber_count_en),
    .serdes_wr(serdes_wr), .serdes_rd(serdes_rd), .serdes_wdata(serdes_wdata),
    .serdes_dev(serdes_dev), .serdes_vendor_space(serdes_vendor_space),
    .serdes_reg_offs(serdes_reg_offs), .mac_full_duplex(mac_full_duplex),
    .mac_tx_fc_en(mac_tx_fc_en), .mac_rx_fc_en(mac_rx_fc_en), .mac_speed(mac_speed)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Register-backed outputs land one edge after the storing edge
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // Strap is sampled right after release, so requests wait two edges
  task automatic t_reset(input logic strap);
    @(posedge clk);
    rst <= 1'b1;
    fc_strap <= strap;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK({xover_auto_en, pairing_straight}, 2'b10)
    `CHK(jabber_count_en, 1'b1)
    `CHK(mac_full_duplex, 1'b1)
    `CHK({mac_tx_fc_en, mac_rx_fc_en}, {strap, strap})
    `CHK(mac_speed, SPEED_1000)
    rd(OFF_SD_ADDR, rv);
    `CHK(rv, 32'h001F0000)
    rd(OFF_PP0, rv);
    `CHK(rv, {24'h0, 2'b01, strap, 1'b1, strap, 3'b000})
    rd(OFF_XOVER, rv);
    `CHK(rv, 32'h0)
    $display("reset test done, strap %0b", strap);
  endtask : t_reset

  task automatic t_xover();
    logic [15:0] xw [4] = '{16'hFFFF, 16'h0040, 16'hAABF, 16'h0000};
    logic [1:0] xe [4] = '{2'b01, 2'b00, 2'b10, 2'b10};
    for (int i = 0; i < 4; i++) begin
      wr(OFF_XOVER, {16'hFFFF, xw[i]});
      settle();
      `CHK({xover_auto_en, pairing_straight}, xe[i])
      rd(OFF_XOVER, rv);
      `CHK(rv, {24'h0, xw[i][7:6], 6'h0})
    end
    $display("crossover test done");
  endtask : t_xover

  // Status is sampled ahead of the read, so inputs settle a few cycles first
  task automatic t_status();
    logic [4:0] st [3] = '{5'b10101, 5'b01000, 5'b00110};
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        wr(OFF_XCVR, 32'hFFFF_FDFF);
        settle();
        `CHK(jabber_count_en, 1'b0)
      end
      @(posedge clk);
      {sp1000, sp100, sp10, full_dup, master} <= st[i % 3];
      repeat (3) @(posedge clk);
      rd(OFF_XCVR, rv);
      `CHK(rv, {22'h0, i < 3, 2'b10, st[i % 3], 2'b00})
    end
    wr(OFF_XCVR, 32'h0000_0200);
    settle();
    `CHK(jabber_count_en, 1'b1)
    $display("transceiver status test done");
  endtask : t_status

  task automatic t_indirect();
    wr(OFF_SD_ADDR, 32'h008080FF);
    wr(OFF_SD_DATA, 32'hFFFF1234);
    #1;
    `CHK({serdes_wr, serdes_rd, serdes_wdata}, {2'b10, 16'h1234})
    `CHK({serdes_dev, serdes_vendor_space, serdes_reg_offs}, {5'h00, 1'b1, 8'hFF})
    settle();
    `CHK(serdes_wr, 1'b0)
    rd(OFF_SD_DATA, rv);
    `CHK(rv, 32'h0000BEEF)
    `CHK({serdes_rd, serdes_vendor_space, serdes_reg_offs}, {1'b1, 1'b1, 8'h00})
    rd(OFF_SD_ADDR, rv);
    `CHK(rv, 32'h00808101)
    wr(OFF_SD_ADDR, 32'hFF7E0003);
    rd(OFF_SD_ADDR, rv);
    `CHK(rv, 32'h001E0003)
    for (int i = 0; i < 2; i++) begin
      wr(OFF_SD_DATA, 32'h0000A5A5);
      #1;
      `CHK({serdes_wr, serdes_dev, serdes_vendor_space, serdes_reg_offs}, {1'b1, 5'h1E, 1'b0, 8'h03})
    end
    rd(OFF_SD_ADDR, rv);
    `CHK(rv, 32'h001E0003)
    wr(16'h0204, 32'hFFFFFFFF);
    rd(16'h0204, rv);
    `CHK(rv, 32'h0)
    $display("indirect window test done");
  endtask : t_indirect

  task automatic t_mac();
    wr(OFF_PP0, 32'h0);
    settle();
    `CHK({mac_full_duplex, mac_tx_fc_en, mac_rx_fc_en}, 3'b000)
    `CHK(mac_speed, SPEED_1000)
    wr(OFF_PP1, 32'h40);
    settle();
    `CHK(mac_speed, SPEED_10)
    wr(OFF_PP0, 32'h10);
    settle();
    `CHK(mac_speed, SPEED_100)
    wr(OFF_PP0, 32'h20);
    settle();
    `CHK({mac_full_duplex, mac_tx_fc_en, mac_rx_fc_en}, 3'b010)
    wr(OFF_PP0, 32'h48);
    settle();
    `CHK({mac_full_duplex, mac_tx_fc_en, mac_rx_fc_en}, 3'b101)
    wr(OFF_PP0, 32'hEF);
    settle();
    `CHK({mac_full_duplex, mac_tx_fc_en, mac_rx_fc_en, mac_speed}, {3'b111, SPEED_10})
    rd(OFF_PP0, rv);
    `CHK(rv, 32'h68)
    rd(OFF_PP1, rv);
    `CHK(rv, 32'h40)
    wr(OFF_PP1, 32'h0);
    settle();
    `CHK(mac_speed, SPEED_1000)
    $display("parallel port test done");
  endtask : t_mac

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // Whole run is about 150 cycles; this margin only catches a hang
  initial begin
    #100000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
    fc_strap = 1'b1;
    serdes_rdata = 16'hBEEF;
    {sp1000, sp100, sp10, full_dup, master} = 5'h00;
    t_reset(1'b1);
    t_xover();
    t_status();
    t_indirect();
    t_mac();
    t_reset(1'b0);
    conclude();
  end
endmodule : tb
`default_nettype wire
